// File: rtl/gesc_pkg.sv
// package: register map, field layout and carrier types of the pin control block
package gesc_pkg;
    // register indices, byte address is four times the index
    localparam logic [5:0]  PIN_CFG_IDX  = 6'h06;
    localparam logic [5:0]  STATUS_IDX   = 6'h08;
    localparam logic [5:0]  MASK_IDX     = 6'h09;
    localparam logic [5:0]  CTRL_IDX     = 6'h0a;
    localparam int          ADDR_W       = 8;
    localparam logic [7:0]  PIN_CFG_ADDR = {PIN_CFG_IDX, 2'h0};
    localparam logic [7:0]  STATUS_ADDR  = {STATUS_IDX, 2'h0};
    localparam logic [7:0]  MASK_ADDR    = {MASK_IDX, 2'h0};
    localparam logic [7:0]  CTRL_ADDR    = {CTRL_IDX, 2'h0};
    // pin configuration fields
    localparam logic [15:0] PIN_CFG_RST  = 16'h0800;
    localparam logic [15:0] PIN_CFG_WMSK = 16'h3fc0;
    localparam int          OUT_EN_BIT   = 13;
    localparam int          OPEN_WIRE_ENABLE_BIT    = 12;
    localparam int          HOLD_EN_BIT  = 11;
    localparam int          ERR_MODE_HI  = 10;
    localparam int          ERR_MODE_LO  = 9;
    localparam int          PIN_DATA_BIT = 8;
    localparam int          LVL1_BIT     = 7;
    localparam int          LVL0_BIT     = 6;
    // error pin modes
    localparam logic [1:0]  ERR_OFF      = 2'h0;
    localparam logic [1:0]  ERR_IN       = 2'h1;
    localparam logic [1:0]  ERR_OD       = 2'h2;
    localparam logic [1:0]  ERR_GPO      = 2'h3;
    // event bits of status and mask, control bit
    localparam int          EVT_W        = 3;
    localparam int          EVT_ERR      = 0;
    localparam int          EVT_HOLD     = 1;
    localparam int          EVT_RESUME   = 2;
    localparam int          ALT_BIT      = 0;

    typedef enum logic [0:0] {GESC_RUN, GESC_BLOCKED} gesc_hold_t;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } gesc_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } gesc_apb_rsp_t;

    typedef struct packed {
        logic o;   // level driven
        logic oe;  // high while driven
    } gesc_pin_t;
endpackage : gesc_pkg

// File: rtl/gesc_top.sv
// pin configuration register with output, hold and error pin logic behind an apb slave
//
// Overview of operation
// R1 - the pin configuration register sits at index 0x06 and resets to 0x0800, only hold enable set.
// R2 - bit 13 enables both general outputs together and both are disabled when it is 0.
// R3 - bit 7 sets the second output level and bit 6 the first, 1 high and 0 low.
// R4 - bit 12 enables open wire detection on the voltage channels and is clear after reset.
// R5 - with bit 11 set a low hold input keeps converter and filter in reset until it goes high.
// R6 - in alternative hold mode with several channels a low hold blocks the next conversion at the switch.
// R7 - in alternative hold mode the blocked conversion starts when the hold input goes high.
// R8 - bits 10:9 pick the error pin mode and 00, the reset value, leaves the pin disabled.
// R9 - in mode 01 the pin is an active low input whose inverse is ORed into the converter error flag.
// R10 - with the pin as input, reading the error data bit returns the sampled pin level.
// R11 - in mode 10 the pin is an active low open drain output, the inverted OR of the error bits.
// R12 - in mode 11 the pin is a plain pushed output whose level comes only from the data bit.
// R13 - bit 8 sets the level driven in plain output mode, 1 high and 0 low.
// R14 - the open drain error pins of several devices may share one pull-up as a common line.
// R15 - reserved bits 15:14 and 5:0 read as zero and ignore writes.
`timescale 1ns/1ps
module gesc_top (
    input  wire logic                   clk_i,            // 25 mhz clock
    input  wire logic                   reset_i,          // synchronous reset, high
    input  wire gesc_pkg::gesc_apb_req_t apb_i,           // apb request
    output gesc_pkg::gesc_apb_rsp_t     apb_o,            // apb answer
    input  wire logic                   hold_i,           // hold input, low holds
    input  wire logic                   multi_channel_i,  // more than one channel enabled
    input  wire logic                   channel_switch_i, // sequencer due to switch channel
    input  wire logic                   int_error_i,      // OR of internal error bits
    input  wire logic                   err_pin_i,        // error pin level
    output gesc_pkg::gesc_pin_t         err_pin_o,        // error pin drive
    output logic                        out_lvl0_o,       // first general output
    output logic                        out_lvl1_o,       // second general output
    output logic                        gpo_oe_o,         // general outputs enabled
    output logic                        open_wire_en_o,   // open wire detection on
    output logic                        conv_reset_o,     // converter and filter in reset
    output logic                        conv_block_o,     // next conversion held back
    output logic                        conv_start_o,     // pulse, start pending conversion
    output logic                        adc_error_o,      // converter error flag
    output logic                        irq_o             // interrupt, level high
);
    typedef struct packed {
        logic [15:0]             cfg;
        logic [gesc_pkg::EVT_W-1:0] status;
        logic [gesc_pkg::EVT_W-1:0] mask;
        logic                    alt_mode;
        gesc_pkg::gesc_apb_rsp_t rsp;
        gesc_pkg::gesc_hold_t    hold;
        logic                    conv_reset;
        logic                    conv_block;
        logic                    conv_start;
        logic                    adc_err;
        gesc_pkg::gesc_pin_t     err_pin;
        logic                    out_lvl0;
        logic                    out_lvl1;
        logic                    gpo_oe;
        logic                    open_wire_enable;
        logic                    irq;
    } gesc_state_t;

    gesc_state_t st_ff;
    gesc_state_t nxt_st;
    logic        setup;
    logic        done;
    logic        hit;
    logic [1:0]  mode;
    logic        hold_en;
    logic        alt_act;
    logic [15:0] cfg_rd;
    logic [gesc_pkg::EVT_W-1:0] evt;

    // decode of the bus phases and the live mode bits
    always_comb begin
        setup   = apb_i.psel && !apb_i.penable;
        done    = apb_i.psel && apb_i.penable && st_ff.rsp.pready;
        hit     = apb_i.paddr == gesc_pkg::PIN_CFG_ADDR || apb_i.paddr == gesc_pkg::STATUS_ADDR
               || apb_i.paddr == gesc_pkg::MASK_ADDR || apb_i.paddr == gesc_pkg::CTRL_ADDR;
        mode    = st_ff.cfg[gesc_pkg::ERR_MODE_HI:gesc_pkg::ERR_MODE_LO];
        hold_en = st_ff.cfg[gesc_pkg::HOLD_EN_BIT];
        alt_act = st_ff.alt_mode && multi_channel_i;
        // reserved bits masked, data bit shows the pin in input mode
        cfg_rd  = st_ff.cfg & gesc_pkg::PIN_CFG_WMSK;  // R15
        if (mode == gesc_pkg::ERR_IN) begin
            cfg_rd[gesc_pkg::PIN_DATA_BIT] = err_pin_i;  // R10
        end
    end

    // next state: bus slave, registers, hold sequencing, pins
    always_comb begin
        nxt_st = st_ff;
        evt    = '0;
        // answer one cycle after setup, data fixed for the access phase
        nxt_st.rsp.pready = setup;
        if (setup) begin
            nxt_st.rsp.prdata  = '0;
            nxt_st.rsp.pslverr = !hit;
            if (!apb_i.pwrite) begin
                case (apb_i.paddr)
                    gesc_pkg::PIN_CFG_ADDR: nxt_st.rsp.prdata[15:0] = cfg_rd;  // R1 R10
                    gesc_pkg::STATUS_ADDR:  nxt_st.rsp.prdata[gesc_pkg::EVT_W-1:0] = st_ff.status;
                    gesc_pkg::MASK_ADDR:    nxt_st.rsp.prdata[gesc_pkg::EVT_W-1:0] = st_ff.mask;
                    gesc_pkg::CTRL_ADDR:    nxt_st.rsp.prdata[gesc_pkg::ALT_BIT] = st_ff.alt_mode;
                    default:                nxt_st.rsp.prdata = '0;
                endcase
            end
        end
        // writes take effect on the completing edge only
        if (done && apb_i.pwrite) begin
            case (apb_i.paddr)
                gesc_pkg::PIN_CFG_ADDR: nxt_st.cfg = apb_i.pwdata[15:0] & gesc_pkg::PIN_CFG_WMSK;  // R15
                gesc_pkg::MASK_ADDR:    nxt_st.mask = apb_i.pwdata[gesc_pkg::EVT_W-1:0];
                gesc_pkg::CTRL_ADDR:    nxt_st.alt_mode = apb_i.pwdata[gesc_pkg::ALT_BIT];
                default:                nxt_st.mask = st_ff.mask;
            endcase
        end
        // read clears only the bits that were reported
        if (done && !apb_i.pwrite && apb_i.paddr == gesc_pkg::STATUS_ADDR) begin
            nxt_st.status = st_ff.status & ~st_ff.rsp.prdata[gesc_pkg::EVT_W-1:0];
        end

        // plain hold: low input keeps converter and filter in reset
        nxt_st.conv_reset = hold_en && !alt_act && !hold_i;  // R5
        nxt_st.conv_start = 1'b0;
        case (st_ff.hold)
            gesc_pkg::GESC_RUN: begin
                if (hold_en && alt_act && channel_switch_i && !hold_i) begin
                    nxt_st.hold = gesc_pkg::GESC_BLOCKED;  // R6
                end
            end
            gesc_pkg::GESC_BLOCKED: begin
                // release starts the pending conversion
                if (hold_i || !hold_en || !alt_act) begin
                    nxt_st.hold       = gesc_pkg::GESC_RUN;
                    nxt_st.conv_start = 1'b1;  // R7
                end
            end
            default: nxt_st.hold = gesc_pkg::GESC_RUN;
        endcase
        nxt_st.conv_block = nxt_st.hold == gesc_pkg::GESC_BLOCKED;  // R6

        // error flag takes the inverted pin only in input mode
        nxt_st.adc_err = int_error_i || (mode == gesc_pkg::ERR_IN && !err_pin_i);  // R9
        case (mode)
            gesc_pkg::ERR_IN:  nxt_st.err_pin = '{o: 1'b0, oe: 1'b0};
            // open drain: pull low while an error bit is set, else release
            gesc_pkg::ERR_OD:  nxt_st.err_pin = '{o: 1'b0, oe: int_error_i};  // R11 R14
            gesc_pkg::ERR_GPO: nxt_st.err_pin =
                '{o: st_ff.cfg[gesc_pkg::PIN_DATA_BIT], oe: 1'b1};  // R12 R13
            default:           nxt_st.err_pin = '{o: 1'b0, oe: 1'b0};  // R8
        endcase

        // general outputs and open wire follow the register at once
        nxt_st.gpo_oe   = nxt_st.cfg[gesc_pkg::OUT_EN_BIT];  // R2
        nxt_st.out_lvl1 = nxt_st.gpo_oe && nxt_st.cfg[gesc_pkg::LVL1_BIT];  // R3
        nxt_st.out_lvl0 = nxt_st.gpo_oe && nxt_st.cfg[gesc_pkg::LVL0_BIT];  // R3
        nxt_st.open_wire_enable    = nxt_st.cfg[gesc_pkg::OPEN_WIRE_ENABLE_BIT];  // R4

        // sticky events, a set wins over a read clear
        evt[gesc_pkg::EVT_ERR]    = nxt_st.adc_err && !st_ff.adc_err;
        evt[gesc_pkg::EVT_HOLD]   = (nxt_st.conv_reset && !st_ff.conv_reset)
                                 || (nxt_st.conv_block && !st_ff.conv_block);
        evt[gesc_pkg::EVT_RESUME] = nxt_st.conv_start;
        nxt_st.status = nxt_st.status | evt;
        nxt_st.irq    = |(nxt_st.status & nxt_st.mask);

        if (reset_i) begin
            nxt_st     = '0;
            nxt_st.cfg = gesc_pkg::PIN_CFG_RST;  // R1
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        st_ff <= nxt_st;
    end

    // outputs straight from the state flops
    assign apb_o          = st_ff.rsp;
    assign err_pin_o      = st_ff.err_pin;
    assign out_lvl0_o     = st_ff.out_lvl0;
    assign out_lvl1_o     = st_ff.out_lvl1;
    assign gpo_oe_o       = st_ff.gpo_oe;
    assign open_wire_en_o = st_ff.open_wire_enable;
    assign conv_reset_o   = st_ff.conv_reset;
    assign conv_block_o   = st_ff.conv_block;
    assign conv_start_o   = st_ff.conv_start;
    assign adc_error_o    = st_ff.adc_err;
    assign irq_o          = st_ff.irq;

    // checks on the register and pin behaviour
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    cfg_reset_val_a: assert property ($past(reset_i) && !reset_i |-> // R1
        st_ff.cfg == gesc_pkg::PIN_CFG_RST && !gpo_oe_o && !err_pin_o.oe)
        else $error("pin configuration not at reset value");

    gpo_enable_a: assert property (done && apb_i.pwrite // R2
        && apb_i.paddr == gesc_pkg::PIN_CFG_ADDR
        |=> gpo_oe_o == $past(apb_i.pwdata[gesc_pkg::OUT_EN_BIT]))
        else $error("general output enable does not follow write");

    gpo_levels_a: assert property (gpo_oe_o |-> // R3
        out_lvl1_o == st_ff.cfg[gesc_pkg::LVL1_BIT]
        && out_lvl0_o == st_ff.cfg[gesc_pkg::LVL0_BIT])
        else $error("general output level differs from register");

    open_wire_a: assert property (done && apb_i.pwrite // R4
        && apb_i.paddr == gesc_pkg::PIN_CFG_ADDR
        |=> open_wire_en_o == $past(apb_i.pwdata[gesc_pkg::OPEN_WIRE_ENABLE_BIT]))
        else $error("open wire enable does not follow write");

    hold_reset_a: assert property (hold_en && !alt_act && !hold_i |=> conv_reset_o) // R5
        else $error("low hold did not reset converter");

    alt_block_a: assert property (hold_en && alt_act && channel_switch_i && !hold_i // R6
        |=> conv_block_o && !conv_reset_o)
        else $error("alternative hold did not block conversion");

    alt_resume_a: assert property (conv_block_o && hold_i |=> conv_start_o ##1 !conv_start_o) // R7
        else $error("pending conversion not started on hold release");

    err_input_a: assert property (mode == gesc_pkg::ERR_IN && !err_pin_i |=> adc_error_o) // R9
        else $error("low error input not in error flag");

    err_readback_a: assert property (setup && !apb_i.pwrite && mode == gesc_pkg::ERR_IN // R10
        && apb_i.paddr == gesc_pkg::PIN_CFG_ADDR
        |=> apb_o.prdata[gesc_pkg::PIN_DATA_BIT] == $past(err_pin_i))
        else $error("error data bit does not show pin");

    err_drain_a: assert property (mode == gesc_pkg::ERR_OD |=> // R11
        !err_pin_o.o && err_pin_o.oe == $past(int_error_i))
        else $error("open drain error output wrong");

    err_gpo_a: assert property (mode == gesc_pkg::ERR_GPO |=> // R12
        err_pin_o.oe && err_pin_o.o == $past(st_ff.cfg[gesc_pkg::PIN_DATA_BIT]))
        else $error("plain error output wrong");

    err_off_a: assert property (mode == gesc_pkg::ERR_OFF |=> !err_pin_o.oe) // R8
        else $error("disabled error pin is driven");

    reserved_zero_a: assert property (apb_o.pready && !apb_i.pwrite // R15
        && apb_i.paddr == gesc_pkg::PIN_CFG_ADDR
        |-> (apb_o.prdata[15:0] & ~gesc_pkg::PIN_CFG_WMSK) == 16'h0000)
        else $error("reserved bits read nonzero");

    // bus slave timing: one access cycle, single ready pulse
    bus_ready_a: assert property (setup |=> apb_o.pready) // R1
        else $error("no ready after setup");

    ready_pulse_a: assert property (apb_o.pready |=> !apb_o.pready) // R1
        else $error("ready stands longer than one cycle");

    unmapped_err_a: assert property (setup && !hit // R1
        |=> apb_o.pslverr && apb_o.prdata == 32'h0000_0000)
        else $error("unmapped access not refused");

    // stored configuration keeps only the writable bits
    cfg_write_a: assert property (done && apb_i.pwrite // R15
        && apb_i.paddr == gesc_pkg::PIN_CFG_ADDR
        |=> st_ff.cfg == ($past(apb_i.pwdata[15:0]) & gesc_pkg::PIN_CFG_WMSK))
        else $error("configuration write not stored");

    // general outputs low while disabled
    gpo_off_a: assert property (!gpo_oe_o |-> !out_lvl0_o && !out_lvl1_o) // R2
        else $error("disabled general output drives high");

    ow_follow_a: assert property (open_wire_en_o == st_ff.cfg[gesc_pkg::OPEN_WIRE_ENABLE_BIT]) // R4
        else $error("open wire enable differs from register");

    // hold reset only when enabled, plain mode and input low
    hold_off_a: assert property (!hold_en |=> !conv_reset_o) // R5
        else $error("converter reset with hold disabled");

    hold_high_a: assert property (hold_i |=> !conv_reset_o) // R5
        else $error("converter reset with hold input high");

    alt_no_reset_a: assert property (alt_act |=> !conv_reset_o) // R6
        else $error("alternative hold reset the filter");

    // start is a single pulse and ends the block
    start_pulse_a: assert property (conv_start_o |=> !conv_start_o) // R7
        else $error("start pulse longer than one cycle");

    block_release_a: assert property (conv_block_o && hold_i |=> !conv_block_o) // R7
        else $error("block not released on hold high");

    // error pin as input is never driven, internal errors always flagged
    err_in_float_a: assert property (mode == gesc_pkg::ERR_IN |=> !err_pin_o.oe) // R9
        else $error("error input is driven");

    err_internal_a: assert property (int_error_i |=> adc_error_o) // R9
        else $error("internal error not in error flag");

    // stored data bit reads back outside input mode
    err_stored_a: assert property (setup && !apb_i.pwrite && mode != gesc_pkg::ERR_IN // R13
        && apb_i.paddr == gesc_pkg::PIN_CFG_ADDR
        |=> apb_o.prdata[gesc_pkg::PIN_DATA_BIT] == $past(st_ff.cfg[gesc_pkg::PIN_DATA_BIT]))
        else $error("error data bit readback wrong");

    // interrupt level and sticky hold event
    irq_level_a: assert property (irq_o == (|(st_ff.status & st_ff.mask))) // R5
        else $error("interrupt differs from masked status");

    status_sticky_a: assert property (st_ff.status[gesc_pkg::EVT_HOLD] // R5
        && !(done && !apb_i.pwrite && apb_i.paddr == gesc_pkg::STATUS_ADDR)
        |=> st_ff.status[gesc_pkg::EVT_HOLD])
        else $error("hold event lost without read");
endmodule : gesc_top

// File: sim/gesc_ext_model.sv
// error line model: shared open drain wire with pull up and a second device
`timescale 1ns/1ps
module gesc_ext_model (
    input  wire gesc_pkg::gesc_pin_t pin_i,       // error pin drive of the block
    input  wire logic                other_low_i, // second device pulls line low
    output logic                     line_o       // resolved error line
);
    // pull up holds the line high unless a driver pulls it low
    assign line_o = (pin_i.oe ? pin_i.o : 1'b1) & ~other_low_i;
endmodule : gesc_ext_model

// File: sim/gesc_top_tb.sv
// self checking bench of the pin control block
`timescale 1ns/1ps
module gesc_top_tb;
    logic                    clk_i     = 1'b0;
    logic                    reset_i   = 1'b1;
    gesc_pkg::gesc_apb_req_t apb_i     = '0;
    gesc_pkg::gesc_apb_rsp_t apb_o;
    gesc_pkg::gesc_pin_t     err_pin;
    logic                    hold_i    = 1'b1;
    logic                    multi_i   = 1'b0;
    logic                    switch_i  = 1'b0;
    logic                    int_err_i = 1'b0;
    logic                    other_low = 1'b0;
    logic                    err_line;
    logic                    lvl0, lvl1, gpo_oe, open_wire_enable, c_rst, c_blk, c_start, adc_err, irq;
    logic [31:0]             rd;
    logic                    rerr;
    int                      err_count = 0;
    int                      checked   = 0;
    int                      cycles    = 0;

    // 25 mhz clock
    always #20 clk_i = ~clk_i;

    gesc_top dut_u (.clk_i(clk_i), .reset_i(reset_i), .apb_i(apb_i), .apb_o(apb_o),
        .hold_i(hold_i), .multi_channel_i(multi_i), .channel_switch_i(switch_i),
        .int_error_i(int_err_i), .err_pin_i(err_line), .err_pin_o(err_pin),
        .out_lvl0_o(lvl0), .out_lvl1_o(lvl1), .gpo_oe_o(gpo_oe), .open_wire_en_o(open_wire_enable),
        .conv_reset_o(c_rst), .conv_block_o(c_blk), .conv_start_o(c_start),
        .adc_error_o(adc_err), .irq_o(irq));

    gesc_ext_model ext_u (.pin_i(err_pin), .other_low_i(other_low), .line_o(err_line));

    task automatic end_sim;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask : chk

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        @(posedge clk_i);
        apb_i.psel    <= 1'b1;
        apb_i.penable <= 1'b0;
        apb_i.pwrite  <= wr;
        apb_i.paddr   <= addr;
        apb_i.pwdata  <= wd;
        @(posedge clk_i);
        apb_i.penable <= 1'b1;
        // sample ready at the edge itself, data taken there too
        do begin
            @(posedge clk_i);
        end while (apb_o.pready !== 1'b1);
        rd   = apb_o.prdata;
        rerr = apb_o.pslverr;
        apb_i.psel    <= 1'b0;
        apb_i.penable <= 1'b0;
    endtask : apb

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick

    task automatic t_reset;
        apb(1'b0, gesc_pkg::PIN_CFG_ADDR, 32'h0);
        chk("cfg reset", 32'h0000_0800, rd);
        chk("outputs reset", 32'h0, 32'({gpo_oe, open_wire_enable, err_pin.oe}));
    endtask : t_reset

    task automatic t_fields;
        apb(1'b1, gesc_pkg::PIN_CFG_ADDR, 32'hffff_ffff);
        apb(1'b0, gesc_pkg::PIN_CFG_ADDR, 32'h0);
        chk("cfg reserved", 32'h0000_3fc0, rd);
        chk("all on", 32'h3f, 32'({gpo_oe, lvl1, lvl0, open_wire_enable, err_pin.oe, err_pin.o}));
        apb(1'b1, gesc_pkg::PIN_CFG_ADDR, 32'h2680);
        tick(2);
        chk("levels", 32'h32, 32'({gpo_oe, lvl1, lvl0, open_wire_enable, err_pin.oe, err_pin.o}));
        apb(1'b1, gesc_pkg::PIN_CFG_ADDR, 32'h0040);
        tick(2);
        chk("outputs off", 32'h0, 32'({gpo_oe, lvl1, lvl0}));
    endtask : t_fields

    task automatic t_errpin;
        apb(1'b1, gesc_pkg::PIN_CFG_ADDR, 32'h0a00);
        @(posedge clk_i) other_low <= 1'b1;
        tick(2);
        chk("in mode drive", 32'h0, 32'(err_pin.oe));
        chk("pin error", 32'h1, 32'(adc_err));
        apb(1'b0, gesc_pkg::PIN_CFG_ADDR, 32'h0);
        chk("pin data low", 32'h0, 32'(rd[8]));
        @(posedge clk_i) other_low <= 1'b0;
        tick(2);
        chk("pin idle", 32'h0, 32'(adc_err));
        apb(1'b0, gesc_pkg::PIN_CFG_ADDR, 32'h0);
        chk("pin data high", 32'h1, 32'(rd[8]));
        @(posedge clk_i) int_err_i <= 1'b1;
        tick(2);
        chk("internal error", 32'h1, 32'(adc_err));
        apb(1'b1, gesc_pkg::PIN_CFG_ADDR, 32'h0c00);
        tick(2);
        chk("od drive", 32'h2, 32'({err_pin.oe, err_pin.o}));
        chk("od line low", 32'h0, 32'(err_line));
        @(posedge clk_i) int_err_i <= 1'b0;
        tick(2);
        chk("od released", 32'h1, 32'(err_line));
        apb(1'b1, gesc_pkg::PIN_CFG_ADDR, 32'h0800);
        tick(2);
        chk("pin off", 32'h0, 32'(err_pin.oe));
    endtask : t_errpin

    task automatic t_hold;
        @(posedge clk_i) hold_i <= 1'b0;
        tick(2);
        chk("hold reset", 32'h1, 32'({c_blk, c_rst}));
        @(posedge clk_i) hold_i <= 1'b1;
        tick(2);
        chk("hold release", 32'h0, 32'(c_rst));
        apb(1'b1, gesc_pkg::PIN_CFG_ADDR, 32'h0);
        @(posedge clk_i) hold_i <= 1'b0;
        tick(2);
        chk("hold disabled", 32'h0, 32'(c_rst));
        @(posedge clk_i) hold_i <= 1'b1;
        apb(1'b1, gesc_pkg::PIN_CFG_ADDR, 32'h0800);
    endtask : t_hold

    task automatic t_alt;
        apb(1'b1, gesc_pkg::CTRL_ADDR, 32'h1);
        @(posedge clk_i);
        multi_i <= 1'b1;
        hold_i  <= 1'b0;
        tick(2);
        chk("alt no reset", 32'h0, 32'({c_blk, c_rst}));
        @(posedge clk_i) switch_i <= 1'b1;
        @(posedge clk_i) switch_i <= 1'b0;
        #1;
        chk("alt block", 32'h1, 32'(c_blk));
        tick(3);
        chk("block held", 32'h2, 32'({c_blk, c_start}));
        @(posedge clk_i) hold_i <= 1'b1;
        tick(1);
        chk("resume", 32'h1, 32'({c_blk, c_start}));
        tick(1);
        chk("start pulse", 32'h0, 32'(c_start));
        apb(1'b1, gesc_pkg::CTRL_ADDR, 32'h0);
        @(posedge clk_i) multi_i <= 1'b0;
    endtask : t_alt

    task automatic t_irq;
        apb(1'b1, gesc_pkg::MASK_ADDR, 32'h0);
        apb(1'b0, gesc_pkg::STATUS_ADDR, 32'h0);
        @(posedge clk_i) hold_i <= 1'b0;
        tick(2);
        @(posedge clk_i) hold_i <= 1'b1;
        tick(2);
        chk("irq masked", 32'h0, 32'(irq));
        apb(1'b1, gesc_pkg::MASK_ADDR, 32'h1 << gesc_pkg::EVT_HOLD);
        apb(1'b1, gesc_pkg::STATUS_ADDR, 32'h0);
        tick(2);
        chk("irq raised", 32'h1, 32'(irq));
        apb(1'b0, gesc_pkg::STATUS_ADDR, 32'h0);
        chk("status hold", 32'h2, rd & 32'h2);
        tick(2);
        chk("irq cleared", 32'h0, 32'(irq));
        apb(1'b1, 8'hfc, 32'h1);
        chk("unmapped write", 32'h1, 32'(rerr));
        apb(1'b0, 8'hfc, 32'h0);
        chk("unmapped read", 32'h1, {rd[30:0], rerr});
    endtask : t_irq

    // reset, then the scenarios in turn
    initial begin
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        t_reset();
        t_fields();
        t_errpin();
        t_hold();
        t_alt();
        t_irq();
        end_sim();
    end

    // hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            end_sim();
        end
    end
endmodule : gesc_top_tb
